// ===== logic/eeprom_pkg.sv
// shared constants and types for the two-wire serial eeprom target
// assumes a 10 MHz core clock that samples the bus pins
package eeprom_pkg;

  // ----------------------------------------------------------------
  // clocking and write cycle
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int WR_TIME_NS = 3000000;
  // longest time, so the division rounds down
  localparam int WR_CYCLES = WR_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // array geometry and address word fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int ARRAY_BYTES = 32768;
  localparam logic [3:0] TYPE_MAIN = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int TYPE_ID_BIT = 4;
  localparam int ID_LOCK_SEL_BIT = 2;
  localparam int LOCK_DATA_BIT = 1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_TX_ACK = 3'b100
  } bus_state_t;

  typedef enum logic [1:0] {
    K_DEV = 2'b00,
    K_AHI = 2'b01,
    K_ALO = 2'b10,
    K_DATA = 2'b11
  } byte_kind_t;

endpackage

// ===== logic/pin_sync.sv
// two-flop synchroniser for one pin, with edge pulses taken after it
// assumes the pin is asynchronous to ref_clk_i and idles at RST_VAL
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // pin and synchronised view
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic prev;

  // the first flop feeds only the second one
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      meta <= RST_VAL;
      level_o <= RST_VAL;
      prev <= RST_VAL;
    end else begin
      meta <= pin_i;
      level_o <= meta;
      prev <= level_o;
    end
  end

  assign rise_o = level_o && !prev;
  assign fall_o = !level_o && prev;

endmodule // pin_sync

// ===== logic/small_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
// assumes DEPTH is a power of two; flush empties it in one cycle
`timescale 1ns/1ps
module small_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] slot [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign in_ready_o = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = slot[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      slot[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || flush_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // small_fifo

// ===== logic/eeprom_target.sv
// two-wire serial eeprom target: main array, identification page, write cycle
// assumes scl, sda, write protect and chip selects come from pins, sampled here
//
// Notes on behaviour
// - sda falling while scl high is a start; every command begins with one.
// - sda rising while scl high is a stop; then standby once writes finish.
// - bits sampled on scl rise, driven after scl fall.
// - words are eight bits; device pulls sda low on the ninth clock to ack.
// - nine dummy clocks then start and stop bring the device back to idle.
// - an eight bit device address follows each start; top nibble is type code.
// - three chip select bits compared with hard-wired inputs; floating reads low.
// - last address bit one means read, zero means write.
// - matching address is acked; mismatch gets no ack and device goes idle.
// - write protect high blocks all writes to the main array.
// - main array is 512 pages of 64 bytes, 15-bit word address.
// - byte write is address, two address bytes, data, stop, then timed write.
// - page write sends up to 64 data bytes, each acked, ended by stop.
// - only low six address bits advance during write, wrapping in the page.
// - id page write uses type 1011 with lock select zero; locked means nack.
// - during the write cycle addresses are not acked; ack returns when done.
// - address counter holds last address plus one; reads wrap at array end.
// - current read sends the byte at the counter after the read address.
// - random read loads address by dummy write, repeated start, then read.
// - each controller ack advances the address and sends the next byte.
// - id page read uses type 1011; offset is the low six address bits.
// - type 1011, lock select one, data bit one set locks the id page.
`timescale 1ns/1ps
module eeprom_target
  import eeprom_pkg::*;
#(
  parameter int WRITE_CYCLES = WR_CYCLES,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // straps
  input wire logic [2:0] chip_select_inputs_i,
  input wire logic write_protect_i,
  // status
  output logic standby_o,
  output logic busy_o
);

  localparam int TW = $clog2(WRITE_CYCLES + 1);
  localparam int BW = ADDR_W + 8;

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  logic scl_s, scl_rise, scl_fall;
  logic sda_s, sda_rise, sda_fall;
  logic wp_s;
  logic [2:0] cs_meta, cs_s;

  pin_sync #(.RST_VAL(1'b1)) u_scl (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(scl_i),
    .level_o(scl_s), .rise_o(scl_rise), .fall_o(scl_fall));
  pin_sync #(.RST_VAL(1'b1)) u_sda (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(sda_i),
    .level_o(sda_s), .rise_o(sda_rise), .fall_o(sda_fall));
  pin_sync #(.RST_VAL(1'b0)) u_wp (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .pin_i(write_protect_i),
    .level_o(wp_s), .rise_o(), .fall_o());

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cs_meta <= 3'h0;
      cs_s <= 3'h0;
    end else begin
      cs_meta <= chip_select_inputs_i;
      cs_s <= cs_meta;
    end
  end

  logic start_det, stop_det;
  assign start_det = scl_s && sda_fall;
  assign stop_det = scl_s && sda_rise;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem [0:ARRAY_BYTES-1];
  logic [7:0] id_mem [0:PAGE_BYTES-1];
  logic [7:0] page_lat [0:PAGE_BYTES-1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  bus_state_t state;
  byte_kind_t kind;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic sel_id, rd_dir, id_lock_sel, host_ack, locked, lock_req, wr_id, wr_block, busy;
  logic [ADDR_W-1:0] waddr, addr_cnt, raddr, last_addr;
  logic [PAGE_BYTES-1:0] page_mask;
  logic [ADDR_W-PAGE_W-1:0] wr_page;
  logic [TW-1:0] timer;
  logic [PAGE_W:0] commit_idx;
  logic fetch_on;

  // ----------------------------------------------------------------
  // byte decisions
  // ----------------------------------------------------------------
  logic rx_done, dev_match, give_ack, data_take, rd_start, tx_next, tx_end, pop;
  logic buf_in_ready, buf_valid, buf_flush, wr_go;
  logic [BW-1:0] buf_data;
  logic [7:0] rdata, tx_byte;

  assign rx_done = (state == ST_RX) && scl_fall && (bitcnt == 4'h8) && !start_det && !stop_det;
  assign dev_match = ((shreg[7:4] == TYPE_MAIN) || (shreg[7:4] == TYPE_ID))
    && (shreg[3:1] == cs_s)
    && !busy;

  always_comb begin
    case (kind)
      K_DEV: give_ack = dev_match;
      K_AHI: give_ack = 1'b1;
      K_ALO: give_ack = 1'b1;
      K_DATA: give_ack = !(sel_id && !id_lock_sel && locked);
      default: give_ack = 1'b0;
    endcase
  end

  assign data_take = rx_done && (kind == K_DATA) && give_ack;
  assign rd_start = (state == ST_RX_ACK) && scl_fall && rd_dir && !start_det && !stop_det;
  assign tx_next = (state == ST_TX_ACK) && scl_fall && host_ack && !start_det && !stop_det;
  assign tx_end = (state == ST_TX_ACK) && scl_fall && !host_ack;
  assign pop = rd_start || tx_next;
  assign tx_byte = buf_valid ? buf_data[7:0] : IDLE_BYTE;
  assign buf_flush = start_det || stop_det || tx_end;
  assign wr_go = stop_det && !busy && ((|page_mask) || lock_req);

  // ----------------------------------------------------------------
  // bit level sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      kind <= K_DEV;
      bitcnt <= 4'h0;
      shreg <= BYTE_RST;
      sda_oe_o <= 1'b0;
      sel_id <= 1'b0;
      rd_dir <= 1'b0;
      host_ack <= 1'b0;
    end else if (start_det) begin
      state <= ST_RX;
      kind <= K_DEV;
      bitcnt <= 4'h0;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      state <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise && bitcnt != 4'h8) begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (rx_done) begin
            if (give_ack) begin
              sda_oe_o <= 1'b1;
              state <= ST_RX_ACK;
            end else begin
              state <= ST_IDLE;
            end
            if (kind == K_DEV) begin
              sel_id <= shreg[TYPE_ID_BIT];
              rd_dir <= shreg[0];
              kind <= K_AHI;
            end else if (kind == K_AHI) begin
              kind <= K_ALO;
            end else begin
              kind <= K_DATA;
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'h0;
            if (rd_dir) begin
              sda_oe_o <= !tx_byte[7];
              shreg <= {tx_byte[6:0], 1'b0};
              bitcnt <= 4'h1;
              state <= ST_TX;
            end else begin
              sda_oe_o <= 1'b0;
              state <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt != 4'h8) begin
              sda_oe_o <= !shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end else begin
              sda_oe_o <= 1'b0;
              state <= ST_TX_ACK;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            host_ack <= !sda_s;
          end else if (tx_next) begin
            sda_oe_o <= !tx_byte[7];
            shreg <= {tx_byte[6:0], 1'b0};
            bitcnt <= 4'h1;
            state <= ST_TX;
          end else if (tx_end) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // word address and address counter
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      waddr <= ADDR_RST;
      addr_cnt <= ADDR_RST;
      id_lock_sel <= 1'b0;
    end else if (rx_done && kind == K_AHI) begin
      waddr[ADDR_W-1:8] <= shreg[ADDR_W-9:0];
      id_lock_sel <= shreg[ID_LOCK_SEL_BIT];
    end else if (rx_done && kind == K_ALO) begin
      waddr[7:0] <= shreg;
      if (!sel_id) begin
        addr_cnt <= {waddr[ADDR_W-1:8], shreg};
      end
    end else if (data_take) begin
      // in-page wrap: the page bits never move during a write
      waddr[PAGE_W-1:0] <= waddr[PAGE_W-1:0] + 6'h01;
      if (!sel_id) begin
        addr_cnt <= {waddr[ADDR_W-1:PAGE_W], waddr[PAGE_W-1:0] + 6'h01};
      end
    end else if (pop && buf_valid && !sel_id) begin
      addr_cnt <= last_addr + 15'h0001;
    end
  end

  // ----------------------------------------------------------------
  // read prefetch into the two-entry buffer
  // ----------------------------------------------------------------
  // the buffer carries each byte's address, so the counter follows what was
  // really sent and not what was fetched ahead
  assign rdata = sel_id ? id_mem[raddr[PAGE_W-1:0]] : mem[raddr];
  assign last_addr = buf_data[BW-1:8];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      fetch_on <= 1'b0;
      raddr <= ADDR_RST;
    end else if (rx_done && kind == K_DEV && give_ack && shreg[0]) begin
      fetch_on <= 1'b1;
      if (shreg[TYPE_ID_BIT]) begin
        raddr <= {9'h000, waddr[PAGE_W-1:0]};
      end else begin
        raddr <= addr_cnt;
      end
    end else if (buf_flush) begin
      fetch_on <= 1'b0;
    end else if (fetch_on && buf_in_ready) begin
      if (sel_id) begin
        raddr[PAGE_W-1:0] <= raddr[PAGE_W-1:0] + 6'h01;
      end else begin
        raddr <= raddr + 15'h0001;
      end
    end
  end

  small_fifo #(.WIDTH(BW), .DEPTH(BUF_DEPTH)) u_rbuf (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(buf_flush),
    .in_valid_i(fetch_on && !buf_flush),
    .in_data_i({raddr, rdata}),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_valid),
    .out_data_o(buf_data),
    .out_ready_i(pop)
  );

  // ----------------------------------------------------------------
  // page latch and lock request
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (data_take && !(sel_id && id_lock_sel)) begin
      page_lat[waddr[PAGE_W-1:0]] <= shreg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      page_mask <= '0;
      lock_req <= 1'b0;
      wr_id <= 1'b0;
      wr_page <= '0;
    end else if (busy && timer == '0) begin
      page_mask <= '0;
      lock_req <= 1'b0;
    end else if (start_det && !busy) begin
      // a write not closed by a stop is dropped
      page_mask <= '0;
      lock_req <= 1'b0;
    end else if (data_take) begin
      wr_id <= sel_id;
      wr_page <= waddr[ADDR_W-1:PAGE_W];
      if (sel_id && id_lock_sel) begin
        lock_req <= lock_req | shreg[LOCK_DATA_BIT];
      end else begin
        page_mask[waddr[PAGE_W-1:0]] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // self-timed write cycle
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      busy <= 1'b0;
      timer <= '0;
      commit_idx <= '0;
      wr_block <= 1'b0;
      locked <= 1'b0;
    end else if (wr_go) begin
      busy <= 1'b1;
      timer <= TW'(WRITE_CYCLES - 1);
      commit_idx <= '0;
      wr_block <= wp_s && !wr_id;
      locked <= locked | lock_req;
    end else if (busy) begin
      if (timer == '0) begin
        busy <= 1'b0;
      end else begin
        timer <= timer - 1'b1;
      end
      if (!commit_idx[PAGE_W]) begin
        commit_idx <= commit_idx + 7'h01;
      end
    end
  end

  logic commit_we;
  assign commit_we = busy && !commit_idx[PAGE_W] && page_mask[commit_idx[PAGE_W-1:0]];

  always_ff @(posedge ref_clk_i) begin
    if (commit_we && !wr_block) begin
      if (wr_id) begin
        id_mem[commit_idx[PAGE_W-1:0]] <= page_lat[commit_idx[PAGE_W-1:0]];
      end else begin
        mem[{wr_page, commit_idx[PAGE_W-1:0]}] <= page_lat[commit_idx[PAGE_W-1:0]];
      end
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sda_o <= 1'b0;
      standby_o <= 1'b1;
      busy_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      standby_o <= (state == ST_IDLE) && !busy && !wr_go;
      busy_o <= busy || wr_go;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_start_restart: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    start_det |=> (state == ST_RX) && (kind == K_DEV) && (bitcnt == 4'h0) && !sda_oe_o)
    else $error("start did not restart address reception");

  a_stop_standby: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    stop_det && !busy && !wr_go && !start_det |=> ##1 standby_o)
    else $error("no standby after stop");

  a_drive_after_fall: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    $rose(sda_oe_o) |-> $past(scl_fall))
    else $error("sda driven outside scl low");

  a_ack_ninth_clock: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rx_done && give_ack |=> sda_oe_o && (state == ST_RX_ACK))
    else $error("received byte not acked");

  a_mismatch_nack: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rx_done && (kind == K_DEV) && (shreg[3:1] != cs_s) |=> !sda_oe_o && (state == ST_IDLE))
    else $error("mismatched address acked");

  a_busy_poll_nack: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rx_done && (kind == K_DEV) && busy |=> !sda_oe_o)
    else $error("address acked during write cycle");

  a_wp_blocks_array: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_go && wp_s && !wr_id |=> wr_block)
    else $error("write protect ignored");

  a_page_wrap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    data_take |=> (waddr[ADDR_W-1:PAGE_W] == $past(waddr[ADDR_W-1:PAGE_W]))
      && (waddr[PAGE_W-1:0] == $past(waddr[PAGE_W-1:0]) + 6'h01))
    else $error("write address left its page");

  a_locked_nack: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    rx_done && (kind == K_DATA) && sel_id && !id_lock_sel && locked |=> !sda_oe_o)
    else $error("data acked into locked id page");

  a_write_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    wr_go |=> busy [*8])
    else $error("write cycle ended early");

endmodule // eeprom_target

// ===== sim/bus_ctrl.sv
// two-wire bus controller model: makes scl, pulls sda low, samples the wire
// assumes the bench resolves sda as open drain with a pull-up
`timescale 1ns/1ps
module bus_ctrl (
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // scl stands high between frames, sda released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // longer low phase here gives the target time to let go of an ack
  task automatic start();
    #100 sda_low_o = 1'b0;
    #400 scl_o = 1'b1;
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask

  task automatic stop();
    #100 sda_low_o = 1'b1;
    #300 scl_o = 1'b1;
    #200 sda_low_o = 1'b0;
    #400;
  endtask

  // eight bits then the ninth; rel high leaves sda released on the ninth
  task automatic xfer(input logic [7:0] tx, input logic rel, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= -1; i--) begin
      #100 sda_low_o = (i >= 0) ? ~tx[i] : ~rel;
      #300 scl_o = 1'b1;
      #200 if (i >= 0) rx[i] = sda_i;
      else ack = ~sda_i;
      #200 scl_o = 1'b0;
    end
  endtask
endmodule // bus_ctrl

// ===== sim/tb_top.sv
// self-checking bench for the eeprom target, driven through a controller model
// assumes a shortened write cycle of 200 core clocks
`timescale 1ns/1ps
module tb_top;
  localparam logic [2:0] CS = 3'h5;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl;
  logic sda_low;
  logic sda_dev;
  logic sda_oe;
  logic wp = 1'b0;
  logic [2:0] cs_pins = CS;
  logic standby;
  logic busy;
  wire sda = ~(sda_low | (sda_oe & ~sda_dev));
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  eeprom_target #(.WRITE_CYCLES(200), .BUF_DEPTH(2)) i_eeprom_target (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_dev), .sda_oe_o(sda_oe),
    .chip_select_inputs_i(cs_pins), .write_protect_i(wp), .standby_o(standby), .busy_o(busy));
  bus_ctrl i_bus_ctrl (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic dev(input logic [3:0] ty, input logic [2:0] cs, input logic rw, output logic ack);
    logic [7:0] rx;
    i_bus_ctrl.start();
    i_bus_ctrl.xfer({ty, cs, rw}, 1'b1, rx, ack);
  endtask

  task automatic wr(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] d[$], input logic dack);
    logic ack;
    logic [7:0] rx;
    dev(ty, CS, 1'b0, ack);
    chk({7'h0, ack}, 8'h01);
    d.push_front(a[7:0]);
    d.push_front(a[15:8]);
    foreach (d[i]) begin
      i_bus_ctrl.xfer(d[i], 1'b1, rx, ack);
      chk({7'h0, ack}, {7'h0, (i < 2) | dack});
    end
    i_bus_ctrl.stop();
  endtask

  task automatic cur(input logic [3:0] ty, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] rx;
    dev(ty, CS, 1'b1, ack);
    chk({7'h0, ack}, 8'h01);
    foreach (e[i]) begin
      i_bus_ctrl.xfer(8'hFF, i == e.size() - 1, rx, ack);
      chk(rx, e[i]);
    end
    i_bus_ctrl.stop();
  endtask

  task automatic rd(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] rx;
    dev(ty, CS, 1'b0, ack);
    i_bus_ctrl.xfer(a[15:8], 1'b1, rx, ack);
    i_bus_ctrl.xfer(a[7:0], 1'b1, rx, ack);
    cur(ty, e);
  endtask

  task automatic wait_idle();
    repeat (4) @(negedge ref_clk_i);
    for (int n = 0; n < 400 && busy !== 1'b0; n++) @(negedge ref_clk_i);
    chk({7'h0, busy}, 8'h00);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_page_poll();
    logic ack;
    wr(4'hA, 16'h013E, '{8'h11, 8'h22, 8'h33}, 1'b1);
    dev(4'hA, CS, 1'b0, ack);
    chk({7'h0, ack}, 8'h00);
    i_bus_ctrl.stop();
    wait_idle();
    dev(4'hA, CS, 1'b0, ack);
    chk({7'h0, ack}, 8'h01);
    i_bus_ctrl.stop();
    rd(4'hA, 16'h013E, '{8'h11, 8'h22});
    rd(4'hA, 16'h0100, '{8'h33});
  endtask

  task automatic t_wrap_wp();
    wr(4'hA, 16'h7FFF, '{8'h5A}, 1'b1);
    wait_idle();
    wr(4'hA, 16'h0000, '{8'hA5}, 1'b1);
    wait_idle();
    rd(4'hA, 16'h7FFF, '{8'h5A});
    cur(4'hA, '{8'hA5});
    rd(4'hA, 16'h7FFF, '{8'h5A, 8'hA5});
    wp = 1'b1;
    wr(4'hA, 16'h0000, '{8'h77}, 1'b1);
    wait_idle();
    wp = 1'b0;
    rd(4'hA, 16'h0000, '{8'hA5});
  endtask

  task automatic t_cs_recover();
    logic ack;
    logic [7:0] rx;
    dev(4'hA, 3'h4, 1'b0, ack);
    chk({7'h0, ack}, 8'h00);
    i_bus_ctrl.stop();
    repeat (8) @(negedge ref_clk_i);
    chk({7'h0, standby}, 8'h01);
    // frame left open after a write-direction address; a read here would clock out unwritten cells
    dev(4'hA, CS, 1'b0, ack);
    chk({7'h0, ack}, 8'h01);
    i_bus_ctrl.xfer(8'hFF, 1'b1, rx, ack);
    i_bus_ctrl.start();
    i_bus_ctrl.stop();
    rd(4'hA, 16'h0000, '{8'hA5});
  endtask

  task automatic t_id_page();
    wr(4'hB, 16'h0005, '{8'hC1, 8'hC2}, 1'b1);
    wait_idle();
    rd(4'hB, 16'h0005, '{8'hC1, 8'hC2});
    wr(4'hB, 16'h0400, '{8'h02}, 1'b1);
    wait_idle();
    wr(4'hB, 16'h0005, '{8'h00}, 1'b0);
    wait_idle();
    rd(4'hB, 16'h0005, '{8'hC1});
  endtask

  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    t_page_poll();
    t_wrap_wp();
    t_cs_recover();
    t_id_page();
    print_verdict();
  end
endmodule // tb_top
